// >>> rtl/iav_pkg.sv
// iav_pkg: constants and types for the interrupt aggregation and vectoring block
// assumes one mclk domain; registers reached over ahb-lite, one aligned word each
package iav_pkg;
  // register byte addresses
  localparam logic [7:0] IAV_OFS_CTRL   = 8'h00;   // irq_control_reg
  localparam logic [7:0] IAV_OFS_PFLAG  = 8'h04;   // periph_flag_reg
  localparam logic [7:0] IAV_OFS_PMASK  = 8'h08;   // periph_mask_reg
  localparam logic [7:0] IAV_OFS_OPT    = 8'h0c;   // option_config_reg
  localparam logic [7:0] IAV_OFS_IOC    = 8'h10;   // per_pin_change_mask
  localparam logic [7:0] IAV_OFS_ISTAT  = 8'h14;   // bus-side sticky event status
  localparam logic [7:0] IAV_OFS_IMASK  = 8'h18;   // bus-side event mask
  localparam logic [7:0] IAV_OFS_CORE   = 8'h1c;   // core state, read only
  // irq_control_reg fields
  localparam int IAV_B_GLB_EN   = 7;
  localparam int IAV_B_GRP_EN   = 6;
  localparam int IAV_B_TMR_EN   = 5;
  localparam int IAV_B_PIN_EN   = 4;
  localparam int IAV_B_PORT_EN  = 3;
  localparam int IAV_B_TMR_FLG  = 2;
  localparam int IAV_B_PIN_FLG  = 1;
  localparam int IAV_B_PORT_FLG = 0;
  localparam int IAV_B_EDGE  = 6;                  // option_config_reg
  localparam logic [7:0] IAV_RST_CTRL = 8'h00;
  localparam logic [7:0] IAV_RST_PER  = 8'h00;
  localparam logic [7:0] IAV_RST_OPT  = 8'hff;
  localparam logic [5:0] IAV_RST_IOC  = 6'h00;
  localparam logic [12:0] IAV_VECTOR  = 13'h0004;
  localparam int IAV_NSRC     = 11;
  localparam int IAV_PIN_W    = 6;
  localparam int IAV_LAT_MIN  = 3;                 // entry latency, instruction cycles
  // bus-side status bits
  localparam int IAV_E_TAKEN  = 0;
  localparam int IAV_E_WAKE   = 1;
  localparam int IAV_E_PIN    = 2;
  localparam int IAV_E_W      = 3;
  // ahb-lite
  localparam logic [1:0] IAV_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] IAV_HSIZE_WORD    = 3'h2;

  typedef struct packed {
    logic        take;      // vector entry this cycle
    logic        wake;      // leave sleep
    logic [12:0] vector;
  } iav_core_req_t;

  typedef struct packed {
    logic irq_return;       // return_from_irq_instr executed
    logic sleeping;         // core is asleep
    logic instr_end;        // an instruction cycle boundary (q1)
  } iav_core_stat_t;

  typedef enum logic [1:0] {
    IAV_RUN   = 2'b00,
    IAV_ARM   = 2'b01,
    IAV_ENTER = 2'b11,
    IAV_SLEEP = 2'b10
  } iav_state_t;
endpackage

// >>> rtl/iav_irq_ctrl.sv
// iav_irq_ctrl: eleven-source interrupt aggregation, vectoring and sleep wake-up
// assumes core pulses on mclk; ext pin and port pins are asynchronous and synchronised here
//
// Functional notes
// - eleven interrupt sources are accepted
// - global enable bit 7 gates all servicing
// - every source has its own enable bit
// - any reset clears global enable
// - return instruction sets global enable again
// - entry clears global enable, pushes, vectors 0004h
// - pin events enter three or four cycles later
// - flags set regardless of any enable
// - clearing global enable suppresses next-cycle entry
// - pin, port, timer flags in control register
// - peripheral flag register holds eight flags
// - pin edge polarity chosen by edge select
// - selected pin edge sets flag, enable masks
// - pin wakes sleep only if enabled before
// - wake executes next instruction, then vectors if global enable set; here the vector follows the three-boundary entry latency
// - timer zero wrap sets its flag
// - port change sets flag, per-pin selectable
`timescale 1ns/100ps
module iav_irq_ctrl #(
  parameter int PORT_W = iav_pkg::IAV_PIN_W
) (
  input  wire logic                   mclk,
  input  wire logic                   resetn,
  input  wire logic                   clk_en,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  input  wire logic                   ext_irq_pin,
  input  wire logic [PORT_W-1:0]      first_io_port,
  input  wire logic                   timer_zero_wrap,
  input  wire logic [7:0]             periph_event,
  input  wire iav_pkg::iav_core_stat_t core_stat,
  output iav_pkg::iav_core_req_t      core_req,
  output logic                        irq
);

  // control state
  logic [7:0]        ctrl;
  logic [7:0]        pflag;
  logic [7:0]        pmask;
  logic [7:0]        opt;
  logic [PORT_W-1:0] ioc;
  logic [iav_pkg::IAV_E_W-1:0] istat;
  logic [iav_pkg::IAV_E_W-1:0] imask;
  iav_pkg::iav_state_t state;
  logic              pin_en_at_sleep;
  logic [1:0]        lat_cnt;

  // synchronisers: first stage feeds only the second
  logic              pin_s1, pin_s2, pin_q;
  logic [PORT_W-1:0] port_s1, port_s2, port_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_s1  <= 1'b0;
      pin_s2  <= 1'b0;
      pin_q   <= 1'b0;
      port_s1 <= '0;
      port_s2 <= '0;
      port_q  <= '0;
    end else if (clk_en) begin
      pin_s1  <= ext_irq_pin;
      pin_s2  <= pin_s1;
      pin_q   <= pin_s2;
      port_s1 <= first_io_port;
      port_s2 <= port_s1;
      port_q  <= port_s2;
    end
  end

  // event detection
  wire edge_sel   = opt[iav_pkg::IAV_B_EDGE];
  wire pin_rise   = pin_s2 & ~pin_q;
  wire pin_fall   = ~pin_s2 & pin_q;
  wire pin_event  = edge_sel ? pin_rise : pin_fall;
  wire port_event = |((port_s2 ^ port_q) & ioc);

  // ahb-lite slave, zero wait states
  logic       ph_wr;
  logic [7:0] ph_addr;
  wire  ap_valid = hsel & hready & htrans[1];
  wire  wr_en    = ph_wr & clk_en;
  wire  wr_ctrl  = wr_en & (ph_addr == iav_pkg::IAV_OFS_CTRL);
  wire  wr_pflag = wr_en & (ph_addr == iav_pkg::IAV_OFS_PFLAG);
  wire  wr_pmask = wr_en & (ph_addr == iav_pkg::IAV_OFS_PMASK);
  wire  wr_opt   = wr_en & (ph_addr == iav_pkg::IAV_OFS_OPT);
  wire  wr_ioc   = wr_en & (ph_addr == iav_pkg::IAV_OFS_IOC);
  wire  wr_istat = wr_en & (ph_addr == iav_pkg::IAV_OFS_ISTAT);
  wire  wr_imask = wr_en & (ph_addr == iav_pkg::IAV_OFS_IMASK);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ph_wr   <= 1'b0;
      ph_addr <= 8'h00;
    end else if (clk_en) begin
      ph_wr   <= ap_valid & hwrite;
      ph_addr <= haddr[7:0];
    end
  end

  logic [7:0] rd_mux;
  always_comb begin
    case (haddr[7:0])
      iav_pkg::IAV_OFS_CTRL:  rd_mux = ctrl;
      iav_pkg::IAV_OFS_PFLAG: rd_mux = pflag;
      iav_pkg::IAV_OFS_PMASK: rd_mux = pmask;
      iav_pkg::IAV_OFS_OPT:   rd_mux = opt;
      iav_pkg::IAV_OFS_IOC:   rd_mux = 8'(ioc);
      iav_pkg::IAV_OFS_ISTAT: rd_mux = 8'(istat);
      iav_pkg::IAV_OFS_IMASK: rd_mux = 8'(imask);
      iav_pkg::IAV_OFS_CORE:  rd_mux = {6'h00, state};
      default:                rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h0000_0000;
    end else if (clk_en && ap_valid && !hwrite) begin
      hrdata <= {24'h00_0000, rd_mux};
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // request logic
  wire [7:0] ctrl_wv   = wr_ctrl ? hwdata[7:0] : ctrl;
  wire       glb_en    = ctrl[iav_pkg::IAV_B_GLB_EN];
  wire       core_pend = (ctrl[iav_pkg::IAV_B_TMR_EN] & ctrl[iav_pkg::IAV_B_TMR_FLG]) |
                         (ctrl[iav_pkg::IAV_B_PIN_EN] & ctrl[iav_pkg::IAV_B_PIN_FLG]) |
                         (ctrl[iav_pkg::IAV_B_PORT_EN] & ctrl[iav_pkg::IAV_B_PORT_FLG]);
  wire       per_pend  = ctrl[iav_pkg::IAV_B_GRP_EN] & |(pflag & pmask);
  wire       pend      = core_pend | per_pend;
  // a write clearing the global enable blocks entry in that same cycle
  wire       glb_en_live = glb_en & ctrl_wv[iav_pkg::IAV_B_GLB_EN];
  wire       req       = pend & glb_en_live;
  wire       lat_done  = (lat_cnt == 2'(iav_pkg::IAV_LAT_MIN - 1));
  wire       take      = (state == iav_pkg::IAV_ENTER) & core_stat.instr_end & glb_en_live;
  wire       wake_src  = pend | (pin_event & pin_en_at_sleep);
  wire       wake      = (state == iav_pkg::IAV_SLEEP) & wake_src;

  // sequencer: entry counted in instruction boundaries so two-cycle instructions
  // do not stretch the latency
  iav_pkg::iav_state_t next_state;
  always_comb begin
    case (state)
      iav_pkg::IAV_RUN:   next_state = core_stat.sleeping ? iav_pkg::IAV_SLEEP :
                                       req ? iav_pkg::IAV_ARM : iav_pkg::IAV_RUN;
      iav_pkg::IAV_ARM:   next_state = !req ? iav_pkg::IAV_RUN :
                                       (lat_done ? iav_pkg::IAV_ENTER : iav_pkg::IAV_ARM);
      iav_pkg::IAV_ENTER: next_state = !glb_en_live ? iav_pkg::IAV_RUN :
                                       (take ? iav_pkg::IAV_RUN : iav_pkg::IAV_ENTER);
      iav_pkg::IAV_SLEEP: next_state = wake ? iav_pkg::IAV_RUN : iav_pkg::IAV_SLEEP;
      default:            next_state = iav_pkg::IAV_RUN;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state   <= iav_pkg::IAV_RUN;
      lat_cnt <= 2'h0;
    end else if (clk_en) begin
      state <= next_state;
      if (state != iav_pkg::IAV_ARM)
        lat_cnt <= 2'h0;
      else if (core_stat.instr_end)
        lat_cnt <= lat_cnt + 2'h1;
    end
  end

  // pin enable latched as sleep is entered
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn)
      pin_en_at_sleep <= 1'b0;
    else if (clk_en && state == iav_pkg::IAV_RUN && core_stat.sleeping)
      pin_en_at_sleep <= ctrl[iav_pkg::IAV_B_PIN_EN];
  end

  // flags: hardware set wins over software clear
  logic [7:0] next_ctrl;
  always_comb begin
    next_ctrl = ctrl_wv;
    if (core_stat.irq_return)
      next_ctrl[iav_pkg::IAV_B_GLB_EN] = 1'b1;
    if (take)
      next_ctrl[iav_pkg::IAV_B_GLB_EN] = 1'b0;
    if (pin_event)
      next_ctrl[iav_pkg::IAV_B_PIN_FLG] = 1'b1;
    if (timer_zero_wrap)
      next_ctrl[iav_pkg::IAV_B_TMR_FLG] = 1'b1;
    if (port_event)
      next_ctrl[iav_pkg::IAV_B_PORT_FLG] = 1'b1;
  end

  wire [7:0] next_pflag = (wr_pflag ? hwdata[7:0] : pflag) | periph_event;
  wire [iav_pkg::IAV_E_W-1:0] ev = {pin_event, wake, take};
  wire [iav_pkg::IAV_E_W-1:0] next_istat =
    (istat & ~(wr_istat ? hwdata[iav_pkg::IAV_E_W-1:0] : '0)) | ev;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl  <= iav_pkg::IAV_RST_CTRL;
      pflag <= iav_pkg::IAV_RST_PER;
      pmask <= iav_pkg::IAV_RST_PER;
      opt   <= iav_pkg::IAV_RST_OPT;
      ioc   <= PORT_W'(iav_pkg::IAV_RST_IOC);
      istat <= '0;
      imask <= '0;
    end else if (clk_en) begin
      ctrl  <= next_ctrl;
      pflag <= next_pflag;
      istat <= next_istat;
      if (wr_pmask) pmask <= hwdata[7:0];
      if (wr_opt)   opt   <= hwdata[7:0];
      if (wr_ioc)   ioc   <= hwdata[PORT_W-1:0];
      if (wr_imask) imask <= hwdata[iav_pkg::IAV_E_W-1:0];
    end
  end

  // core side: wake resumes at the next instruction; the core then sees take
  // once the global enable allows, which yields the vector only after the three-boundary entry latency through arm
  assign core_req.take   = take & clk_en;
  assign core_req.wake   = wake & clk_en;
  assign core_req.vector = iav_pkg::IAV_VECTOR;
  assign irq             = |(istat & imask);

  // assertions
  sequence s_armed;
    state == iav_pkg::IAV_ARM && req;
  endsequence

  sequence s_arm_start;
    clk_en && state == iav_pkg::IAV_RUN && !core_stat.sleeping && req;
  endsequence

  sequence s_sleep_start;
    clk_en && state == iav_pkg::IAV_RUN && core_stat.sleeping;
  endsequence

  sequence s_entry_due;
    clk_en && state == iav_pkg::IAV_ENTER && core_stat.instr_end && glb_en_live;
  endsequence

  take_clears_en_a: assert property (@(posedge mclk) disable iff (!resetn)
    (take && clk_en && !core_stat.irq_return) |=> !ctrl[iav_pkg::IAV_B_GLB_EN])
    else $error("global enable not cleared after entry");

  return_sets_en_a: assert property (@(posedge mclk) disable iff (!resetn)
    (core_stat.irq_return && clk_en && !take) |=> ctrl[iav_pkg::IAV_B_GLB_EN])
    else $error("global enable not set by return");

  no_take_off_a: assert property (@(posedge mclk) disable iff (!resetn)
    core_req.take |-> glb_en)
    else $error("entry while global enable clear");

  en_clear_block_a: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_ctrl && !hwdata[iav_pkg::IAV_B_GLB_EN]) |-> !core_req.take)
    else $error("entry in cycle global enable cleared");

  en_held_off_a: assert property (@(posedge mclk) disable iff (!resetn)
    (clk_en && !core_stat.irq_return && !ctrl[iav_pkg::IAV_B_GLB_EN] &&
     !(wr_ctrl && hwdata[iav_pkg::IAV_B_GLB_EN])) |=> !ctrl[iav_pkg::IAV_B_GLB_EN])
    else $error("global enable set from nowhere");

  pin_flag_set_a: assert property (@(posedge mclk) disable iff (!resetn)
    (pin_event && clk_en) |=> ctrl[iav_pkg::IAV_B_PIN_FLG])
    else $error("pin flag not set");

  pin_flag_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    (clk_en && !wr_ctrl && ctrl[iav_pkg::IAV_B_PIN_FLG]) |=> ctrl[iav_pkg::IAV_B_PIN_FLG])
    else $error("pin flag lost");

  port_flag_set_a: assert property (@(posedge mclk) disable iff (!resetn)
    (port_event && clk_en) |=> ctrl[iav_pkg::IAV_B_PORT_FLG])
    else $error("port flag not set");

  edge_pol_a: assert property (@(posedge mclk) disable iff (!resetn)
    pin_event |-> (pin_s2 == edge_sel) && (pin_s2 != pin_q))
    else $error("wrong pin edge");

  timer_flag_a: assert property (@(posedge mclk) disable iff (!resetn)
    (timer_zero_wrap && clk_en) |=> ctrl[iav_pkg::IAV_B_TMR_FLG])
    else $error("timer flag not set");

  pflag_sticky_a: assert property (@(posedge mclk) disable iff (!resetn)
    (clk_en && !wr_pflag) |=> ((pflag & $past(pflag)) == $past(pflag)))
    else $error("peripheral flag cleared without write");

  group_gate_a: assert property (@(posedge mclk) disable iff (!resetn)
    (!ctrl[iav_pkg::IAV_B_GRP_EN] && !core_pend) |-> !pend)
    else $error("peripheral request passed group gate");

  run_to_arm_a: assert property (@(posedge mclk) disable iff (!resetn)
    s_arm_start |=> state == iav_pkg::IAV_ARM)
    else $error("request not armed");

  entry_bound_a: assert property (@(posedge mclk) disable iff (!resetn)
    s_arm_start |=> ##[0:15] (core_req.take || state == iav_pkg::IAV_RUN))
    else $error("entry late");

  arm_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    s_armed ##0 (clk_en && !lat_done) |=> state == iav_pkg::IAV_ARM)
    else $error("arm left early");

  enter_take_a: assert property (@(posedge mclk) disable iff (!resetn)
    s_entry_due |-> core_req.take)
    else $error("entry missed at boundary");

  take_once_a: assert property (@(posedge mclk) disable iff (!resetn)
    core_req.take |=> !core_req.take)
    else $error("entry repeated");

  vector_addr_a: assert property (@(posedge mclk) disable iff (!resetn)
    core_req.take |-> core_req.vector == iav_pkg::IAV_VECTOR)
    else $error("wrong vector");

  sleep_entry_a: assert property (@(posedge mclk) disable iff (!resetn)
    s_sleep_start |=> state == iav_pkg::IAV_SLEEP)
    else $error("sleep not entered");

  pin_en_latch_a: assert property (@(posedge mclk) disable iff (!resetn)
    s_sleep_start |=> pin_en_at_sleep == $past(ctrl[iav_pkg::IAV_B_PIN_EN]))
    else $error("pin enable not latched");

  wake_leave_a: assert property (@(posedge mclk) disable iff (!resetn)
    core_req.wake |=> state == iav_pkg::IAV_RUN)
    else $error("wake did not resume");

  wake_in_sleep_a: assert property (@(posedge mclk) disable iff (!resetn)
    core_req.wake |-> state == iav_pkg::IAV_SLEEP)
    else $error("wake while awake");

  no_idle_wake_a: assert property (@(posedge mclk) disable iff (!resetn)
    (clk_en && state == iav_pkg::IAV_SLEEP && !pend && !pin_event) |-> !core_req.wake)
    else $error("wake without cause");

  istat_sticky_a: assert property (@(posedge mclk) disable iff (!resetn)
    (clk_en && !wr_istat) |=> ((istat & $past(istat)) == $past(istat)))
    else $error("status bit lost");

  status_irq_a: assert property (@(posedge mclk) disable iff (!resetn)
    (clk_en && take && imask[iav_pkg::IAV_E_TAKEN]) |=> irq)
    else $error("irq not raised");

  periph_flag_a: assert property (@(posedge mclk) disable iff (!resetn)
    (clk_en && |periph_event) |=> ((pflag & $past(periph_event)) == $past(periph_event)))
    else $error("peripheral flag lost");

  entry_latency_a: assert property (@(posedge mclk) disable iff (!resetn)
    (core_req.take) |-> $past(state) != iav_pkg::IAV_RUN)
    else $error("entry without latency");

  armed_to_run_a: assert property (@(posedge mclk) disable iff (!resetn)
    (clk_en && !req && state == iav_pkg::IAV_ARM) |=> state == iav_pkg::IAV_RUN)
    else $error("arm held without request");

  wake_gate_a: assert property (@(posedge mclk) disable iff (!resetn)
    (core_req.wake && !pend) |-> pin_en_at_sleep)
    else $error("wake without enable");

  arm_step_a: assert property (@(posedge mclk) disable iff (!resetn)
    s_armed ##0 (clk_en && core_stat.instr_end && lat_done) |=> state == iav_pkg::IAV_ENTER)
    else $error("arm did not advance");

endmodule // iav_irq_ctrl

// >>> tb/iav_core_model.sv
// iav_core_model: behavioural processor core facing the interrupt block
// assumes core_req is sampled on rising mclk; bench commands return and sleep
`timescale 1ns/100ps
module iav_core_model (
  input  wire logic                   mclk,
  input  wire logic                   resetn,
  input  wire iav_pkg::iav_core_req_t core_req,
  input  wire logic                   do_return,
  input  wire logic                   do_sleep,
  output iav_pkg::iav_core_stat_t     core_stat
);
  logic [1:0] q_cnt;

  // four clocks per instruction cycle, boundary on the first
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q_cnt     <= 2'h0;
      core_stat <= '0;
    end else begin
      q_cnt               <= q_cnt + 2'h1;
      core_stat.instr_end <= (q_cnt == 2'h3);
      core_stat.irq_return <= do_return;
      // wake wins over a late sleep request, core resumes at once
      if (core_req.wake) begin
        core_stat.sleeping <= 1'b0;
      end else if (do_sleep) begin
        core_stat.sleeping <= 1'b1;
      end
    end
  end
endmodule // iav_core_model

// >>> tb/iav_irq_ctrl_bench.sv
// iav_irq_ctrl_bench: self-checking bench for the interrupt block
// assumes iav_core_model as the core; single 250 MHz clock, ahb-lite master here
`timescale 1ns/100ps
module iav_irq_ctrl_bench;
  logic        mclk, resetn, hsel, hwrite, hreadyout, hresp, irq, ext_irq_pin;
  logic        timer_zero_wrap, do_return, do_sleep, rd_dp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [5:0]  first_io_port;
  logic [7:0]  periph_event, ev;
  logic [31:0] haddr, hwdata, hrdata, rnd;
  logic [31:0] rq[$];
  logic [12:0] tq[$];
  int          n_errors, checked, n_wake, i, w, p;
  iav_pkg::iav_core_stat_t core_stat;
  iav_pkg::iav_core_req_t  core_req;

  iav_irq_ctrl u_dut (.mclk(mclk), .resetn(resetn), .clk_en(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ext_irq_pin(ext_irq_pin), .first_io_port(first_io_port),
    .timer_zero_wrap(timer_zero_wrap), .periph_event(periph_event),
    .core_stat(core_stat), .core_req(core_req), .irq(irq));
  iav_core_model u_core (.mclk(mclk), .resetn(resetn), .core_req(core_req),
    .do_return(do_return), .do_sleep(do_sleep), .core_stat(core_stat));

  always #2 mclk = ~mclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic we, input logic [31:0] d);
    @(posedge mclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= we;
    htrans <= iav_pkg::IAV_HTRANS_NONSEQ;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask

  task automatic pev(input logic [7:0] e, input logic t);
    @(posedge mclk);
    periph_event    <= e;
    timer_zero_wrap <= t;
    @(posedge mclk);
    periph_event    <= 8'h00;
    timer_zero_wrap <= 1'b0;
  endtask

  task automatic pin_to(input logic v);
    @(posedge mclk);
    ext_irq_pin <= v;
    repeat (8) @(posedge mclk);
  endtask

  task automatic port_to(input logic [5:0] v);
    @(posedge mclk);
    first_io_port <= v;
    repeat (8) @(posedge mclk);
  endtask

  // counts instruction boundaries until the vector entry shows up
  task automatic wait_take(input int lo, input int hi);
    int n;
    n = 0;
    for (int k = 0; k < 200; k++) begin
      @(posedge mclk);
      if (core_stat.instr_end === 1'b1) n++;
      if (core_req.take === 1'b1) break;
    end
    chk({31'h0, n >= lo && n <= hi}, 32'h1);
  endtask

  task automatic end_sim;
    if (n_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // read data taken at the data-phase edge; every take must have been noted
  always @(posedge mclk) begin
    if (rd_dp && hreadyout === 1'b1) chk(hrdata, rq.pop_front());
    if (hreadyout === 1'b1) rd_dp <= hsel && htrans[1] && !hwrite;
    if (core_req.take === 1'b1) begin
      if (tq.size() == 0) chk(32'h0, 32'h1);
      else chk({19'h0, core_req.vector}, {19'h0, tq.pop_front()});
    end
    if (core_req.wake === 1'b1) n_wake++;
  end

  initial begin
    #200000;
    n_errors++;
    end_sim();
  end

  initial begin
    mclk = 0; resetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0;
    hsize = iav_pkg::IAV_HSIZE_WORD; ext_irq_pin = 0; first_io_port = 0;
    timer_zero_wrap = 0; periph_event = 0; do_return = 0; do_sleep = 0; rd_dp = 0;
    n_errors = 0; checked = 0; n_wake = 0;
    rnd = $urandom(34557);
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    rd(iav_pkg::IAV_OFS_CTRL, 32'h00);
    rd(iav_pkg::IAV_OFS_OPT, 32'hff);
    rd(iav_pkg::IAV_OFS_PFLAG, 32'h00);
    rd(iav_pkg::IAV_OFS_IOC, 32'h00);
    rd(8'h20, 32'h00);
    rnd = $urandom();
    wr(iav_pkg::IAV_OFS_PMASK, rnd);
    rd(iav_pkg::IAV_OFS_PMASK, {24'h0, rnd[7:0]});
    wr(iav_pkg::IAV_OFS_PMASK, 32'h08);
    // all eight peripheral flags and the timer flag set with all control-register enables off, and nothing is serviced
    ev = 8'($urandom_range(1, 254));
    pev(ev, 1'b1);
    rd(iav_pkg::IAV_OFS_PFLAG, {24'h0, ev});
    pev(~ev, 1'b0);
    rd(iav_pkg::IAV_OFS_PFLAG, 32'hff);
    rd(iav_pkg::IAV_OFS_CTRL, 32'h04);
    wr(iav_pkg::IAV_OFS_PFLAG, 32'h0);
    wr(iav_pkg::IAV_OFS_CTRL, 32'h0);
    for (i = 0; i < 4; i++) begin
      if (i == 2) wr(iav_pkg::IAV_OFS_OPT, 32'hbf);
      pin_to(~ext_irq_pin);
      rd(iav_pkg::IAV_OFS_CTRL, ((ext_irq_pin == 1'b1) == (i < 2)) ? 32'h02 : 32'h0);
      wr(iav_pkg::IAV_OFS_CTRL, 32'h0);
    end
    p = $urandom_range(0, 5);
    wr(iav_pkg::IAV_OFS_IOC, 32'h1 << p);
    port_to(6'h1 << ((p + 1) % 6));
    rd(iav_pkg::IAV_OFS_CTRL, 32'h00);
    port_to(first_io_port | (6'h1 << p));
    rd(iav_pkg::IAV_OFS_CTRL, 32'h01);
    // pin entry, then return with the flag cleared first
    pin_to(1'b1);
    wr(iav_pkg::IAV_OFS_CTRL, 32'h90);
    tq.push_back(iav_pkg::IAV_VECTOR);
    @(posedge mclk) ext_irq_pin <= 1'b0;
    wait_take(3, 4);
    rd(iav_pkg::IAV_OFS_CTRL, 32'h12);
    wr(iav_pkg::IAV_OFS_CTRL, 32'h10);
    @(posedge mclk) do_return <= 1'b1;
    @(posedge mclk) do_return <= 1'b0;
    rd(iav_pkg::IAV_OFS_CTRL, 32'h90);
    // timer request held off by a clear global enable, taken once set
    wr(iav_pkg::IAV_OFS_CTRL, 32'h20);
    pev(8'h00, 1'b1);
    repeat (40) @(posedge mclk);
    tq.push_back(iav_pkg::IAV_VECTOR);
    wr(iav_pkg::IAV_OFS_CTRL, 32'ha4);
    wait_take(3, 4);
    // masked peripheral flags stay quiet, group enable gates the rest
    pev(8'hf7, 1'b0);
    wr(iav_pkg::IAV_OFS_CTRL, 32'h80);
    pev(8'h08, 1'b0);
    repeat (40) @(posedge mclk);
    tq.push_back(iav_pkg::IAV_VECTOR);
    wr(iav_pkg::IAV_OFS_CTRL, 32'hc0);
    wr(iav_pkg::IAV_OFS_PMASK, 32'h08);
    @(posedge mclk);
    wait_take(0, 4);
    wr(iav_pkg::IAV_OFS_PFLAG, 32'h0);
    wr(iav_pkg::IAV_OFS_CTRL, 32'h0);
    // sleep: wake with pin enabled, entry only with global enable
    for (i = 0; i < 3; i++) begin
      w = n_wake;
      wr(iav_pkg::IAV_OFS_CTRL, (i == 0) ? 32'h10 : (i == 1) ? 32'h90 : 32'h00);
      @(posedge mclk) do_sleep <= 1'b1;
      @(posedge mclk) do_sleep <= 1'b0;
      repeat (4) @(posedge mclk);
      if (i == 1) tq.push_back(iav_pkg::IAV_VECTOR);
      pin_to(1'b1);
      pin_to(1'b0);
      repeat (60) @(posedge mclk);
      chk(n_wake - w, (i < 2) ? 32'h1 : 32'h0);
      wr(iav_pkg::IAV_OFS_CTRL, 32'h0);
    end
    // sticky status, mask and level interrupt
    wr(iav_pkg::IAV_OFS_IMASK, 32'h0);
    @(negedge mclk) chk({31'h0, irq}, 32'h0);
    rd(iav_pkg::IAV_OFS_ISTAT, 32'h07);
    wr(iav_pkg::IAV_OFS_IMASK, 32'h1);
    @(negedge mclk) chk({31'h0, irq}, 32'h1);
    wr(iav_pkg::IAV_OFS_ISTAT, 32'h7);
    @(negedge mclk) chk({31'h0, irq}, 32'h0);
    rd(iav_pkg::IAV_OFS_ISTAT, 32'h00);
    repeat (4) @(posedge mclk);
    chk(tq.size(), 32'h0);
    end_sim();
  end
endmodule // iav_irq_ctrl_bench
